// ### logic/dsvr_top.v
// Program select, processing rate and volume ramp engine with its register bank.
//
// What this block does
// R01: Program field picks RAM program or ROM programs one, two, three.
// R02: Rate field: follow input, or force 48, 96, 192 kHz.
// R03: Coefficient bit 1 uses ROM defaults, 0 uses host-downloaded coefficients.
// R04: One eight-bit volume code drives both left and right gain.
// R05: Code 0 is +24 dB, half-dB steps down, 0x30 is 0 dB, all-ones mutes.
// R06: Falling ramp updates every 1, 2, 4 samples; code 3 jumps to the target instantly.
// R07: Falling step is 4, 2, 1 or 0.5 dB per update.
// R08: Rising ramp updates every 1, 2, 4 samples; code 3 restores instantly.
// R09: Rising step is 4, 2, 1 or 0.5 dB per update.
// R10: Emergency fall uses its own interval and step settings.
// R11: Applied gain walks toward the target and stops exactly on it.
// R12: Reserved and read-only bits read reset values; writes to them do nothing.
`timescale 1ns/1ns
`include "dsvr_defs.vh"
module dsvr_top (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [7:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [7:0] wb_dat_i,
  output wire [7:0] wb_dat_o,
  output wire       wb_ack_o,
  input  wire       sample_stb,
  input  wire       emergency,
  output reg  [4:0] program_sel_r,
  output reg  [3:0] program_onehot_r,
  output reg  [1:0] processing_rate_choice_r,
  output reg  [2:0] rate_onehot_r,
  output reg        builtin_coefficient_choice_r,
  output reg  [7:0] volume_code_left_r,
  output reg  [7:0] volume_code_right_r,
  output reg        mute_r,
  output reg        ramp_busy_r
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_FALL = 3'b010;
  localparam ST_RISE = 3'b100;

  wire [7:0] pgm_reg;
  wire [7:0] ctrl_reg;
  wire [7:0] vol_reg;
  wire [7:0] ramp_reg;
  wire [7:0] fast_reg;
  wire [7:0] stat;
  wire       tick;
  wire       restart;
  wire [1:0] fall_interval;
  wire [1:0] fall_increment;
  wire [1:0] rise_interval;
  wire [1:0] rise_increment;
  wire [1:0] cur_interval;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [7:0] applied_r;
  reg  [7:0] applied_nxt;
  reg        emerg_r;

  // Step size in half-dB codes: 4 dB is eight codes, 0.5 dB is one.
  function [7:0] step_codes;
    input [1:0] inc;
    begin
      case (inc)
        2'h0:    step_codes = 8'h08;
        2'h1:    step_codes = 8'h04;
        2'h2:    step_codes = 8'h02;
        default: step_codes = 8'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  dsvr_wb_regs u_regs (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .stat_i   (stat),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .pgm_r    (pgm_reg),
    .ctrl_r   (ctrl_reg),
    .vol_r    (vol_reg),
    .ramp_r   (ramp_reg),
    .fast_r   (fast_reg)
  );

  assign stat = {5'h00, emerg_r, state_r[2], state_r[1]};

  // Emergency settings replace the normal falling ones while the fault lasts.
  assign fall_interval  = emerg_r ? fast_reg[`DSVR_FALL_INT_MSB:`DSVR_FALL_INT_LSB]
                                  : ramp_reg[`DSVR_FALL_INT_MSB:`DSVR_FALL_INT_LSB]; // R10
  assign fall_increment = emerg_r ? fast_reg[`DSVR_FALL_INC_MSB:`DSVR_FALL_INC_LSB]
                                  : ramp_reg[`DSVR_FALL_INC_MSB:`DSVR_FALL_INC_LSB]; // R10
  assign rise_interval  = ramp_reg[`DSVR_RISE_INT_MSB:`DSVR_RISE_INT_LSB];
  assign rise_increment = ramp_reg[`DSVR_RISE_INC_MSB:`DSVR_RISE_INC_LSB];
  assign cur_interval   = (state_r == ST_RISE) ? rise_interval : fall_interval;
  // The divider restarts whenever the engine rests, so a new ramp waits a full interval.
  assign restart        = (state_r == ST_IDLE);

  dsvr_tick_div u_div (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .sample_stb (sample_stb),
    .restart    (restart),
    .interval   (cur_interval),
    .tick_r     (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // The target is the register code, or full mute while an emergency is raised.
  reg  [7:0] target;
  reg  [7:0] step;
  reg  [8:0] sum;

  always @* begin
    target      = emerg_r ? `DSVR_VOL_MUTE : vol_reg;
    step        = 8'h00;
    sum         = 9'h000;
    state_nxt   = state_r;
    applied_nxt = applied_r;
    case (state_r)
      ST_IDLE: begin
        if (target > applied_r) begin
          state_nxt = ST_FALL;
        end else if (target < applied_r) begin
          state_nxt = ST_RISE;
        end
      end
      ST_FALL: begin
        if (fall_interval == `DSVR_IVL_INSTANT) begin
          applied_nxt = target; // R06
          state_nxt   = ST_IDLE;
        end else if (target <= applied_r) begin
          state_nxt = ST_IDLE;
        end else if (tick) begin
          step = step_codes(fall_increment); // R07
          sum  = {1'b0, applied_r} + {1'b0, step};
          if (sum >= {1'b0, target}) begin
            applied_nxt = target; // R11
            state_nxt   = ST_IDLE;
          end else begin
            applied_nxt = sum[7:0];
          end
        end
      end
      ST_RISE: begin
        if (rise_interval == `DSVR_IVL_INSTANT) begin
          applied_nxt = target; // R08
          state_nxt   = ST_IDLE;
        end else if (target >= applied_r) begin
          state_nxt = ST_IDLE;
        end else if (tick) begin
          step = step_codes(rise_increment); // R09
          // Nine-bit compare, so a target near mute cannot wrap and let the gain overshoot.
          sum = {1'b0, target} + {1'b0, step};
          if ({1'b0, applied_r} <= sum) begin
            applied_nxt = target; // R11
            state_nxt   = ST_IDLE;
          end else begin
            applied_nxt = applied_r - step;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      state_r   <= ST_IDLE;
      applied_r <= `DSVR_RST_VOL;
      emerg_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      applied_r <= applied_nxt;
      emerg_r   <= emergency;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (srst) begin
      program_sel_r                <= `DSVR_PGM_ROM1;
      program_onehot_r             <= 4'h2;
      processing_rate_choice_r     <= 2'h0;
      rate_onehot_r                <= 3'h0;
      builtin_coefficient_choice_r <= 1'b1;
      volume_code_left_r           <= `DSVR_RST_VOL;
      volume_code_right_r          <= `DSVR_RST_VOL;
      mute_r                       <= 1'b0;
      ramp_busy_r                  <= 1'b0;
    end else begin
      program_sel_r <= pgm_reg[`DSVR_PGM_MSB:0]; // R01
      case (pgm_reg[`DSVR_PGM_MSB:0])
        `DSVR_PGM_RAM:  program_onehot_r <= 4'h1; // R01
        `DSVR_PGM_ROM1: program_onehot_r <= 4'h2;
        `DSVR_PGM_ROM2: program_onehot_r <= 4'h4;
        `DSVR_PGM_ROM3: program_onehot_r <= 4'h8;
        default:        program_onehot_r <= 4'h0;
      endcase
      processing_rate_choice_r <= ctrl_reg[`DSVR_RATE_MSB:`DSVR_RATE_LSB]; // R02
      case (ctrl_reg[`DSVR_RATE_MSB:`DSVR_RATE_LSB])
        2'h1:    rate_onehot_r <= 3'h1; // R02
        2'h2:    rate_onehot_r <= 3'h2;
        2'h3:    rate_onehot_r <= 3'h4;
        default: rate_onehot_r <= 3'h0;
      endcase
      builtin_coefficient_choice_r <= ctrl_reg[`DSVR_COEF_BIT]; // R03
      volume_code_left_r           <= applied_nxt; // R04
      volume_code_right_r          <= applied_nxt; // R04
      mute_r                       <= (applied_nxt == `DSVR_VOL_MUTE); // R05
      ramp_busy_r                  <= (state_nxt != ST_IDLE);
    end
  end
endmodule // dsvr_top

// ### include/dsvr_defs.vh
// Register offsets, field positions, reset values and ramp encodings of the volume ramp block.
`ifndef DSVR_DEFS_VH
`define DSVR_DEFS_VH

`define DSVR_OFS_PGM        8'h40
`define DSVR_OFS_CTRL       8'h46
`define DSVR_OFS_VOL        8'h4C
`define DSVR_OFS_RAMP       8'h4E
`define DSVR_OFS_FAST       8'h4F
`define DSVR_OFS_STAT       8'h60

`define DSVR_RST_PGM        8'h01
`define DSVR_RST_CTRL       8'h01
`define DSVR_RST_VOL        8'h30
`define DSVR_RST_RAMP       8'h33
`define DSVR_RST_FAST       8'h30

`define DSVR_PGM_MSB        4
`define DSVR_PGM_W          5
`define DSVR_PGM_RAM        5'h00
`define DSVR_PGM_ROM1       5'h01
`define DSVR_PGM_ROM2       5'h02
`define DSVR_PGM_ROM3       5'h03

`define DSVR_RATE_MSB       4
`define DSVR_RATE_LSB       3
`define DSVR_COEF_BIT       0
`define DSVR_CTRL_RW_MASK   8'hF9

`define DSVR_FALL_INT_MSB   7
`define DSVR_FALL_INT_LSB   6
`define DSVR_FALL_INC_MSB   5
`define DSVR_FALL_INC_LSB   4
`define DSVR_RISE_INT_MSB   3
`define DSVR_RISE_INT_LSB   2
`define DSVR_RISE_INC_MSB   1
`define DSVR_RISE_INC_LSB   0
`define DSVR_FAST_RW_MASK   8'hF0

`define DSVR_IVL_INSTANT    2'h3
`define DSVR_VOL_MUTE       8'hFF

`endif

// ### logic/dsvr_tick_div.v
// Sample period divider that pulses once every 1, 2 or 4 sample strobes.
`timescale 1ns/1ns
module dsvr_tick_div (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       sample_stb,
  input  wire       restart,
  input  wire [1:0] interval,
  output reg        tick_r
);
  reg  [1:0] cnt_r;
  wire [1:0] last;

  assign last = (interval == 2'h0) ? 2'h0 : (interval == 2'h1) ? 2'h1 : 2'h3;

  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end else if (restart) begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (sample_stb) begin
        if (cnt_r >= last) begin
          cnt_r  <= 2'h0;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
    end
  end
endmodule // dsvr_tick_div

// ### logic/dsvr_wb_regs.v
// Wishbone classic register file for program, control, volume and ramp settings.
`timescale 1ns/1ns
`include "dsvr_defs.vh"
module dsvr_wb_regs (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [7:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [7:0] wb_dat_i,
  input  wire [7:0] stat_i,
  output reg  [7:0] wb_dat_o,
  output reg        wb_ack_o,
  output reg  [7:0] pgm_r,
  output reg  [7:0] ctrl_r,
  output reg  [7:0] vol_r,
  output reg  [7:0] ramp_r,
  output reg  [7:0] fast_r
);
  wire req;
  wire wr;

  // One wait state: ack follows a new request by one edge and drops the cycle after.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];

  always @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
      pgm_r    <= `DSVR_RST_PGM;
      ctrl_r   <= `DSVR_RST_CTRL;
      vol_r    <= `DSVR_RST_VOL;
      ramp_r   <= `DSVR_RST_RAMP;
      fast_r   <= `DSVR_RST_FAST;
    end else begin
      wb_ack_o <= req;
      if (wr) begin
        case (wb_adr_i)
          `DSVR_OFS_PGM:  pgm_r  <= wb_dat_i;
          `DSVR_OFS_CTRL: ctrl_r <= wb_dat_i & `DSVR_CTRL_RW_MASK; // R12
          `DSVR_OFS_VOL:  vol_r  <= wb_dat_i;
          `DSVR_OFS_RAMP: ramp_r <= wb_dat_i;
          `DSVR_OFS_FAST: fast_r <= wb_dat_i & `DSVR_FAST_RW_MASK; // R12
          default:        pgm_r  <= pgm_r;
        endcase
      end
      if (req) begin
        case (wb_adr_i)
          `DSVR_OFS_PGM:  wb_dat_o <= pgm_r;
          `DSVR_OFS_CTRL: wb_dat_o <= ctrl_r;
          `DSVR_OFS_VOL:  wb_dat_o <= vol_r;
          `DSVR_OFS_RAMP: wb_dat_o <= ramp_r;
          `DSVR_OFS_FAST: wb_dat_o <= fast_r;
          `DSVR_OFS_STAT: wb_dat_o <= stat_i;
          default:        wb_dat_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // dsvr_wb_regs

// ### tb/dsvr_properties.sv
// Concurrent checks on the ports of the volume ramp block.
`timescale 1ns/1ns
module dsvr_properties (
  input wire       sys_clk,
  input wire       srst,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [7:0] wb_dat_i,
  input wire [7:0] wb_dat_o,
  input wire       wb_ack_o,
  input wire       sample_stb,
  input wire       emergency,
  input wire [4:0] program_sel_r,
  input wire [3:0] program_onehot_r,
  input wire [1:0] processing_rate_choice_r,
  input wire [2:0] rate_onehot_r,
  input wire       builtin_coefficient_choice_r,
  input wire [7:0] volume_code_left_r,
  input wire [7:0] volume_code_right_r,
  input wire       mute_r,
  input wire       ramp_busy_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ANSWER: assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  AST_LR_SAME: assert property (volume_code_left_r == volume_code_right_r) else $error("channels differ");
  AST_MUTE_FLAG: assert property (mute_r == (volume_code_left_r == 8'hFF)) else $error("mute flag wrong");
  AST_PGM_MAP: assert property (program_onehot_r == (program_sel_r < 5'h04 ? 4'h1 << program_sel_r : 4'h0))
    else $error("program decode wrong");
  AST_RATE_MAP: assert property (rate_onehot_r == (processing_rate_choice_r == 2'h0 ? 3'h0 :
    3'h1 << (processing_rate_choice_r - 2'h1))) else $error("rate decode wrong");
  // An idle engine must never move the applied gain.
  AST_IDLE_HOLD: assert property (!ramp_busy_r && $past(!ramp_busy_r) |-> $stable(volume_code_left_r))
    else $error("gain moved while idle");
  AST_EMERG_BUSY: assert property ($rose(emergency) && !mute_r |-> ##[1:3] ramp_busy_r)
    else $error("emergency did not start a fall");
endmodule // dsvr_properties

bind dsvr_top dsvr_properties u_dsvr_properties (.*);

// ### tb/dsvr_top_tb.sv
// Self-checking bench for the volume ramp block.
`timescale 1ns/1ns
module dsvr_top_tb;
  reg        sys_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sample_stb = 0, emergency = 0;
  reg  [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, rd, last;
  reg  [3:0] wb_sel_i = 4'hF;
  wire [7:0] wb_dat_o, volume_code_left_r, volume_code_right_r;
  wire       wb_ack_o, mute_r, ramp_busy_r, builtin_coefficient_choice_r;
  wire [4:0] program_sel_r;
  wire [3:0] program_onehot_r;
  wire [1:0] processing_rate_choice_r;
  wire [2:0] rate_onehot_r;
  integer    fail_count = 0, compares = 0, cyc_n = 0, i, k, np, nc;
  reg [23:0] rows [0:9] = '{24'h40E3E3, 24'h400000, 24'h400202, 24'h46FFF9, 24'h460808,
                            24'h461010, 24'h460000, 24'h460101, 24'h4F3F30, 24'hAA5500};
  dsvr_top u_dsvr_top (.*);
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge sys_clk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  task chk(input [7:0] s, input [7:0] e);
    compares = compares + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Waits for ack with no limit of its own; the cycle ceiling ends a hung transfer.
  task wb(input w, input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask
  task rst_chk;
    chk(program_onehot_r, 8'h02); chk(rate_onehot_r, 8'h00); chk(builtin_coefficient_choice_r, 8'h01);
    chk(volume_code_left_r, 8'h30); chk(ramp_busy_r, 8'h00);
    wb(0, 8'h40, 0); chk(rd, 8'h01); wb(0, 8'h46, 0); chk(rd, 8'h01);
    wb(0, 8'h4C, 0); chk(rd, 8'h30); wb(0, 8'h4E, 0); chk(rd, 8'h33);
  endtask
  // Counts sample pulses and gain changes until the engine goes idle.
  task ramp(input [7:0] rv, input [7:0] a, input [7:0] d, input em, input [7:0] ev, input [7:0] ep, input [7:0] ec);
    wb(1, 8'h4E, rv);
    wb(1, a, d);
    if (em) emergency <= 1;
    np = 0; nc = 0; last = volume_code_left_r;
    for (k = 0; k < 40; k = k + 1) begin
      repeat (8) @(posedge sys_clk);
      if (volume_code_left_r !== last) nc = nc + 1;
      last = volume_code_left_r;
      if (ramp_busy_r === 1'b0) break;
      sample_stb <= 1;
      @(posedge sys_clk);
      sample_stb <= 0;
      np = np + 1;
    end
    chk(volume_code_left_r, ev); chk(np, ep); chk(nc, ec);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    rst_chk;
    for (i = 0; i < 10; i = i + 1) begin
      wb(1, rows[i][23:16], rows[i][15:8]);
      wb(0, rows[i][23:16], 8'h00);
      chk(rd, rows[i][7:0]);
    end
    chk(program_sel_r, 8'h02); chk(builtin_coefficient_choice_r, 8'h01);
    chk(program_onehot_r, 8'h04);
    wb(1, 8'h46, 8'h18);
    repeat (2) @(posedge sys_clk);
    chk(processing_rate_choice_r, 8'h03); chk(rate_onehot_r, 8'h04);
    chk(builtin_coefficient_choice_r, 8'h00);
    wb(1, 8'h46, 8'h09);
    repeat (2) @(posedge sys_clk);
    chk(rate_onehot_r, 8'h01); chk(builtin_coefficient_choice_r, 8'h01);
    wb_sel_i <= 4'h0;
    wb(1, 8'h40, 8'h1F);
    wb_sel_i <= 4'hF;
    wb(0, 8'h40, 8'h00); chk(rd, 8'h02);
    ramp(8'h33, 8'h4C, 8'h34, 0, 8'h34, 4, 4);
    ramp(8'h00, 8'h4C, 8'h20, 0, 8'h20, 3, 3);
    ramp(8'h10, 8'h4C, 8'h2A, 0, 8'h2A, 3, 3);
    ramp(8'h08, 8'h4C, 8'h1A, 0, 8'h1A, 8, 2);
    ramp(8'hC0, 8'h4C, 8'hFF, 0, 8'hFF, 0, 1);
    ramp(8'h0C, 8'h4C, 8'h30, 0, 8'h30, 0, 1);
    ramp(8'h80, 8'h4F, 8'hC0, 1, 8'hFF, 0, 1);
    chk(mute_r, 8'h01);
    emergency <= 0;
    repeat (6) @(posedge sys_clk);
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    rst_chk;
    tally_and_finish;
  end
endmodule // dsvr_top_tb
